// ### rtl/flash_seq_pkg.sv
// Purpose: Shared constants and types for the flash command sequencer
// Assumes: AHB-Lite register bus, 32-bit words, 25 MHz bus clock
// Notes:   Array window and control registers share one address space
package flash_seq_pkg;
  // Register byte offsets (control block)
  localparam logic [11:0] clock_divider_off   = 12'h000;
  localparam logic [11:0] status_off          = 12'h004;
  localparam logic [11:0] command_off         = 12'h008;
  localparam logic [11:0] operand_addr_off    = 12'h00c;
  localparam logic [11:0] operand_data_off    = 12'h010;
  // Array window: haddr bit 16 high selects the flash array
  localparam int          array_sel_bit       = 16;
  localparam int          ctrl_idx_hi         = 11;
  // Divider field layout
  localparam int          div_w               = 6;
  localparam int          div_loaded_bit      = 7;
  localparam int          prediv8_bit         = 6;
  localparam logic [2:0]  prediv8_count       = 3'h7;
  // Status bit positions
  localparam int          st_buffer_empty_bit = 7;
  localparam int          st_complete_bit     = 6;
  localparam int          st_access_err_bit   = 4;
  localparam int          st_blank_bit        = 2;
  // Command codes
  localparam logic [7:0]  cmd_blank_check     = 8'h05;
  localparam logic [7:0]  cmd_byte_program    = 8'h20;
  localparam logic [7:0]  cmd_burst_program   = 8'h25;
  localparam logic [7:0]  cmd_page_erase      = 8'h40;
  localparam logic [7:0]  cmd_mass_erase      = 8'h41;
  // Durations in divided-clock cycles
  localparam logic [14:0] t_byte_program      = 15'h0009;
  localparam logic [14:0] t_burst_program     = 15'h0004;
  localparam logic [14:0] t_page_erase        = 15'h0fa0;
  localparam logic [14:0] t_mass_erase        = 15'h4e20;
  localparam logic [14:0] t_blank_check       = 15'h0001;
  localparam int          row_bits            = 6;
  localparam int          page_bits           = 9;
  // AHB encodings
  localparam logic [1:0]  htrans_nonseq       = 2'h2;
  localparam logic [2:0]  hsize_word          = 3'h2;

  typedef enum logic [1:0] {
    seq_idle     = 2'b00,
    seq_operands = 2'b01,
    seq_command  = 2'b10,
    seq_running  = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic        buffer_empty;
    logic        complete;
    logic        access_err;
    logic        blank;
  } status_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic [7:0]  cmd;
  } operands_t;
endpackage

// ### rtl/flash_command_sequencer.sv
// Purpose: Flash command sequencer with AHB-Lite slave register access
// Assumes: Single master, whole-word single transfers, clock enable freezes all state
// Notes:   Array writes only latch operands; the cell array itself lies outside
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module flash_command_sequencer (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        clk_en_i,
  input  wire logic        stop_mode_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             flash_busy_o,
  output logic             high_voltage_o
);
  // Stop mode arrives from the power controller domain: three-stage synchroniser
  logic [2:0]              stop_sync_ff;
  logic [2:0]              nxt_stop_sync;
  logic                    stop_ff;
  logic                    nxt_stop;

  // Bus address phase capture
  logic                    dp_valid_ff;
  logic                    dp_write_ff;
  logic [31:0]             dp_addr_ff;
  logic                    nxt_dp_valid;
  logic                    nxt_dp_write;
  logic [31:0]             nxt_dp_addr;
  logic [31:0]             hrdata_ff;
  logic [31:0]             nxt_hrdata;

  // Sequencer state
  flash_seq_pkg::seq_state_t state_ff;
  flash_seq_pkg::seq_state_t nxt_state;
  flash_seq_pkg::status_t    status_ff;
  flash_seq_pkg::status_t    nxt_status;
  flash_seq_pkg::operands_t  ops_ff;
  flash_seq_pkg::operands_t  nxt_ops;
  logic [7:0]              divider_ff;
  logic [7:0]              nxt_divider;
  logic [14:0]             remain_ff;
  logic [14:0]             nxt_remain;
  logic [5:0]              div_cnt_ff;
  logic [5:0]              nxt_div_cnt;
  logic [2:0]              pre_cnt_ff;
  logic [2:0]              nxt_pre_cnt;
  logic                    hv_ff;
  logic                    nxt_hv;
  logic [9:0]              burst_addr_ff;
  logic [9:0]              nxt_burst_addr;
  logic                    burst_valid_ff;
  logic                    nxt_burst_valid;

  // Combinational helpers
  logic                    divided_flash_clock_tick;
  logic                    is_array;
  logic [11:0]             ctrl_off;
  logic                    wr_stb;
  logic                    rd_stb;
  logic                    valid_code;
  logic [14:0]             duration;

  always_comb begin
    nxt_stop_sync = {stop_sync_ff[1:0], stop_mode_i};
    nxt_stop      = stop_ff;
    if (stop_sync_ff[2] == stop_sync_ff[1]) begin
      nxt_stop = stop_sync_ff[2];
    end
  end

  always_comb begin
    nxt_dp_valid = 1'b0;
    nxt_dp_write = dp_write_ff;
    nxt_dp_addr  = dp_addr_ff;
    if (hready_i && hsel_i && htrans_i == flash_seq_pkg::htrans_nonseq
        && hsize_i == flash_seq_pkg::hsize_word) begin
      nxt_dp_valid = 1'b1;
      nxt_dp_write = hwrite_i;
      nxt_dp_addr  = haddr_i;
    end
  end

  assign is_array = dp_addr_ff[flash_seq_pkg::array_sel_bit];
  assign ctrl_off = dp_addr_ff[flash_seq_pkg::ctrl_idx_hi:0];
  assign wr_stb   = dp_valid_ff && dp_write_ff;
  assign rd_stb   = dp_valid_ff && !dp_write_ff;

  // Divided clock tick: bus clock / (8 if prediv) / (div+1)
  assign divided_flash_clock_tick = divider_ff[flash_seq_pkg::div_loaded_bit] && div_cnt_ff == '0
                     && (!divider_ff[flash_seq_pkg::prediv8_bit] || pre_cnt_ff == '0);

  always_comb begin
    valid_code = 1'b0;
    duration   = flash_seq_pkg::t_blank_check;
    case (hwdata_i[7:0])
      flash_seq_pkg::cmd_blank_check:   valid_code = 1'b1;
      flash_seq_pkg::cmd_byte_program:  begin
        valid_code = 1'b1;
      end
      flash_seq_pkg::cmd_burst_program: valid_code = 1'b1;
      flash_seq_pkg::cmd_page_erase:    valid_code = 1'b1;
      flash_seq_pkg::cmd_mass_erase:    valid_code = 1'b1;
      default:                          valid_code = 1'b0;
    endcase
    case (ops_ff.cmd)
      flash_seq_pkg::cmd_byte_program:  duration = flash_seq_pkg::t_byte_program;
      flash_seq_pkg::cmd_burst_program: begin
        // Same row, not its first byte, and voltage still up: burst time, else standard time
        if (burst_valid_ff && hv_ff
            && ops_ff.addr[15:flash_seq_pkg::row_bits] == burst_addr_ff
            && ops_ff.addr[flash_seq_pkg::row_bits-1:0] != '0) begin
          duration = flash_seq_pkg::t_burst_program;
        end else begin
          duration = flash_seq_pkg::t_byte_program;
        end
      end
      flash_seq_pkg::cmd_page_erase:    duration = flash_seq_pkg::t_page_erase;
      flash_seq_pkg::cmd_mass_erase:    duration = flash_seq_pkg::t_mass_erase;
      default:                          duration = flash_seq_pkg::t_blank_check;
    endcase
  end

  always_comb begin
    nxt_state       = state_ff;
    nxt_status      = status_ff;
    nxt_ops         = ops_ff;
    nxt_divider     = divider_ff;
    nxt_remain      = remain_ff;
    nxt_div_cnt     = div_cnt_ff;
    nxt_pre_cnt     = pre_cnt_ff;
    nxt_hv          = hv_ff;
    nxt_burst_addr  = burst_addr_ff;
    nxt_burst_valid = burst_valid_ff;
    nxt_hrdata      = hrdata_ff;

    if (divider_ff[flash_seq_pkg::div_loaded_bit]) begin
      if (!divider_ff[flash_seq_pkg::prediv8_bit] || pre_cnt_ff == '0) begin
        nxt_pre_cnt = flash_seq_pkg::prediv8_count;
        nxt_div_cnt = (div_cnt_ff == '0) ? divider_ff[flash_seq_pkg::div_w-1:0] : div_cnt_ff - 6'h01;
      end else begin
        nxt_pre_cnt = pre_cnt_ff - 3'h1;
      end
    end

    if (state_ff == flash_seq_pkg::seq_running) begin
      if (stop_ff) begin
        nxt_state               = flash_seq_pkg::seq_idle;
        nxt_status.access_err   = 1'b1;
        nxt_status.buffer_empty = 1'b1;
        nxt_status.complete     = 1'b1;
        nxt_hv                  = 1'b0;
        nxt_burst_valid         = 1'b0;
      end else if (divided_flash_clock_tick) begin
        if (remain_ff == 15'h0001) begin
          nxt_state               = flash_seq_pkg::seq_idle;
          nxt_status.complete     = 1'b1;
          nxt_status.buffer_empty = 1'b1;
          nxt_status.blank        = (ops_ff.cmd == flash_seq_pkg::cmd_blank_check);
          // Voltage stays up only after a burst byte
          nxt_hv = (ops_ff.cmd == flash_seq_pkg::cmd_burst_program);
          nxt_burst_valid = (ops_ff.cmd == flash_seq_pkg::cmd_burst_program);
          nxt_burst_addr  = ops_ff.addr[15:flash_seq_pkg::row_bits];
        end else begin
          nxt_remain = remain_ff - 15'h0001;
        end
      end
    end else if (state_ff == flash_seq_pkg::seq_idle && hv_ff && divided_flash_clock_tick) begin
      // No burst queued in time: drop voltage
      nxt_hv = 1'b0;
    end

    if (rd_stb && !is_array) begin
      if (state_ff == flash_seq_pkg::seq_command && ctrl_off != flash_seq_pkg::status_off) begin
        nxt_status.access_err = 1'b1;
        nxt_state             = flash_seq_pkg::seq_idle;
      end
    end

    if (wr_stb && is_array) begin
      if (!divider_ff[flash_seq_pkg::div_loaded_bit] || status_ff.access_err) begin
        nxt_status.access_err = 1'b1;
      end else if (!status_ff.buffer_empty) begin
        nxt_status.access_err = 1'b1;
      end else if (state_ff != flash_seq_pkg::seq_idle) begin
        nxt_status.access_err = 1'b1;
        nxt_state             = flash_seq_pkg::seq_idle;
      end else begin
        nxt_ops.addr = dp_addr_ff[15:0];
        nxt_ops.data = hwdata_i[7:0];
        nxt_state    = flash_seq_pkg::seq_operands;
      end
    end else if (wr_stb) begin
      case (ctrl_off)
        flash_seq_pkg::clock_divider_off: begin
          if (state_ff != flash_seq_pkg::seq_idle && state_ff != flash_seq_pkg::seq_running) begin
            nxt_status.access_err = 1'b1;
            nxt_state             = flash_seq_pkg::seq_idle;
          end else if (!divider_ff[flash_seq_pkg::div_loaded_bit] && !status_ff.access_err) begin
            nxt_divider = {1'b1, hwdata_i[flash_seq_pkg::prediv8_bit:0]};
          end
        end
        flash_seq_pkg::command_off: begin
          if (state_ff == flash_seq_pkg::seq_operands && valid_code) begin
            nxt_ops.cmd = hwdata_i[7:0];
            nxt_state   = flash_seq_pkg::seq_command;
          end else if (state_ff != flash_seq_pkg::seq_running) begin
            nxt_status.access_err = 1'b1;
            nxt_state             = flash_seq_pkg::seq_idle;
          end
        end
        flash_seq_pkg::status_off: begin
          // A stop-mode abort in the same cycle wins over the clear
          if (hwdata_i[flash_seq_pkg::st_access_err_bit]
              && !(state_ff == flash_seq_pkg::seq_running && stop_ff)) begin
            nxt_status.access_err = 1'b0;
          end
          if (state_ff == flash_seq_pkg::seq_command && hwdata_i[flash_seq_pkg::st_buffer_empty_bit]
              && !status_ff.access_err) begin
            nxt_state               = flash_seq_pkg::seq_running;
            nxt_status.buffer_empty = 1'b0;
            nxt_status.complete     = 1'b0;
            nxt_status.blank        = 1'b0;
            nxt_remain              = duration;
          end else if ((state_ff == flash_seq_pkg::seq_operands || state_ff == flash_seq_pkg::seq_command)
                       && !hwdata_i[flash_seq_pkg::st_buffer_empty_bit]) begin
            nxt_state             = flash_seq_pkg::seq_idle;
            nxt_status.access_err = 1'b1;
          end
        end
        default: begin
          if (state_ff == flash_seq_pkg::seq_operands || state_ff == flash_seq_pkg::seq_command) begin
            nxt_status.access_err = 1'b1;
            nxt_state             = flash_seq_pkg::seq_idle;
          end
        end
      endcase
    end

    // Read data is picked in the address phase from the next-state values, so it stands
    // through the data phase and already shows a write finishing in the same cycle
    if (nxt_dp_valid && !nxt_dp_write) begin
      nxt_hrdata = '0;
      if (!nxt_dp_addr[flash_seq_pkg::array_sel_bit]) begin
        case (nxt_dp_addr[flash_seq_pkg::ctrl_idx_hi:0])
          flash_seq_pkg::clock_divider_off: nxt_hrdata = {24'h000000, nxt_divider};
          flash_seq_pkg::status_off: begin
            nxt_hrdata[flash_seq_pkg::st_buffer_empty_bit] = nxt_status.buffer_empty;
            nxt_hrdata[flash_seq_pkg::st_complete_bit]     = nxt_status.complete;
            nxt_hrdata[flash_seq_pkg::st_access_err_bit]   = nxt_status.access_err;
            nxt_hrdata[flash_seq_pkg::st_blank_bit]        = nxt_status.blank;
          end
          flash_seq_pkg::command_off:      nxt_hrdata = {24'h000000, nxt_ops.cmd};
          flash_seq_pkg::operand_addr_off: nxt_hrdata = {16'h0000, nxt_ops.addr};
          flash_seq_pkg::operand_data_off: nxt_hrdata = {24'h000000, nxt_ops.data};
          default:                         nxt_hrdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stop_sync_ff   <= '0;
      stop_ff        <= 1'b0;
      dp_valid_ff    <= 1'b0;
      dp_write_ff    <= 1'b0;
      dp_addr_ff     <= '0;
      hrdata_ff      <= '0;
      state_ff       <= flash_seq_pkg::seq_idle;
      status_ff      <= '{buffer_empty: 1'b1, complete: 1'b1, access_err: 1'b0, blank: 1'b0};
      ops_ff         <= '0;
      divider_ff     <= '0;
      remain_ff      <= '0;
      div_cnt_ff     <= '0;
      pre_cnt_ff     <= '0;
      hv_ff          <= 1'b0;
      burst_addr_ff  <= '0;
      burst_valid_ff <= 1'b0;
    end else if (clk_en_i) begin
      stop_sync_ff   <= nxt_stop_sync;
      stop_ff        <= nxt_stop;
      dp_valid_ff    <= nxt_dp_valid;
      dp_write_ff    <= nxt_dp_write;
      dp_addr_ff     <= nxt_dp_addr;
      hrdata_ff      <= nxt_hrdata;
      state_ff       <= nxt_state;
      status_ff      <= nxt_status;
      ops_ff         <= nxt_ops;
      divider_ff     <= nxt_divider;
      remain_ff      <= nxt_remain;
      div_cnt_ff     <= nxt_div_cnt;
      pre_cnt_ff     <= nxt_pre_cnt;
      hv_ff          <= nxt_hv;
      burst_addr_ff  <= nxt_burst_addr;
      burst_valid_ff <= nxt_burst_valid;
    end
  end

  // Zero-wait slave: hreadyout stays high so every answer comes in the data phase
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hreadyout_o    <= 1'b1;
      hresp_o        <= 1'b0;
      flash_busy_o   <= 1'b0;
      high_voltage_o <= 1'b0;
    end else if (clk_en_i) begin
      hreadyout_o    <= 1'b1;
      hresp_o        <= 1'b0;
      flash_busy_o   <= (nxt_state == flash_seq_pkg::seq_running);
      high_voltage_o <= nxt_hv || (nxt_state == flash_seq_pkg::seq_running);
    end
  end

  assign hrdata_o = hrdata_ff;
endmodule // flash_command_sequencer

// ### test/flash_bus_master.sv
// Purpose: AHB-Lite master standing in for the processor bus
// Assumes: Single whole-word transfers, one slave whose hreadyout is hready
// Notes:   Write data is inverted in each address phase so stale data never matches
`timescale 1ns/1ns
module flash_bus_master (
  input  wire logic        mclk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h0;
    hwdata_o = 32'h0;
  end

  // Read data is taken at the edge that ends the data phase
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    htrans_o <= flash_seq_pkg::htrans_nonseq;
    hwrite_o <= wr;
    hsize_o <= flash_seq_pkg::hsize_word;
    hwdata_o <= ~hwdata_o;
    do @(posedge mclk_i); while (hready_i !== 1'b1);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= wd;
    do @(posedge mclk_i); while (hready_i !== 1'b1);
    rd = hrdata_i;
  endtask
endmodule // flash_bus_master

// ### test/flash_command_sequencer_sva.sv
// Purpose: Port-level checks of the flash command sequencer
// Assumes: Whole-word transfers only
// Notes:   Launch and divider writes are decoded from the bus data phase
`timescale 1ns/1ns
module flash_command_sequencer_sva (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        clk_en_i,
  input  wire logic        stop_mode_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_o,
  input  wire logic        hreadyout_o,
  input  wire logic        hresp_o,
  input  wire logic        flash_busy_o,
  input  wire logic        high_voltage_o
);
  logic        wr_ph_ff, rd_ph_ff, div_ff, nxt_wr_ph, nxt_rd_ph, nxt_div, take, ctl;
  logic [31:0] a_ff, nxt_a;
  logic [9:0]  since_ff, idle_ff, nxt_since, nxt_idle;
  assign take = hsel_i & hready_i & (htrans_i == flash_seq_pkg::htrans_nonseq);
  assign ctl = wr_ph_ff & !a_ff[flash_seq_pkg::array_sel_bit];
  always_comb begin
    nxt_wr_ph = take & hwrite_i;
    nxt_rd_ph = take & !hwrite_i;
    nxt_a = take ? haddr_i : a_ff;
    nxt_div = div_ff | (ctl & (a_ff[11:0] == flash_seq_pkg::clock_divider_off));
    nxt_since = (since_ff != 10'h3ff) ? since_ff + 10'h1 : since_ff;
    if (ctl & (a_ff[11:0] == flash_seq_pkg::status_off) & hwdata_i[7]) begin
      nxt_since = 10'h0;
    end
    nxt_idle = flash_busy_o ? 10'h0 : ((idle_ff != 10'h3ff) ? idle_ff + 10'h1 : idle_ff);
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {wr_ph_ff, rd_ph_ff, div_ff, a_ff, since_ff, idle_ff} <= {35'h0, 10'h3ff, 10'h0};
    end else begin
      {wr_ph_ff, rd_ph_ff, div_ff, a_ff, since_ff, idle_ff} <= {nxt_wr_ph, nxt_rd_ph, nxt_div, nxt_a, nxt_since, nxt_idle};
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence stop_held_s;
    stop_mode_i [*8];
  endsequence
  ready_ok_a: assert property (hreadyout_o == 1'b1) else $error("hreadyout low");
  resp_ok_a: assert property (hresp_o == 1'b0) else $error("hresp not okay");
  launch_start_a: assert property ($rose(flash_busy_o) |-> since_ff <= 10'h003)
    else $error("busy without launch");
  div_first_a: assert property (flash_busy_o |-> div_ff)
    else $error("busy before divider write");
  stop_abort_a: assert property (stop_held_s |-> !flash_busy_o)
    else $error("busy during stop");
  rdata_hold_a: assert property (!$stable(hrdata_o) |-> rd_ph_ff) else $error("read data moved");
  pump_busy_a: assert property ($rose(high_voltage_o) |-> flash_busy_o)
    else $error("pump on while idle");
  pump_idle_a: assert property (idle_ff > 10'h208 |-> !high_voltage_o)
    else $error("pump held too long");
endmodule // flash_command_sequencer_sva
bind flash_command_sequencer flash_command_sequencer_sva u_sva (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .clk_en_i(clk_en_i), .stop_mode_i(stop_mode_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .flash_busy_o(flash_busy_o), .high_voltage_o(high_voltage_o));

// ### test/tb_flash_command_sequencer.sv
// Purpose: Self-checking bench for the flash command sequencer
// Assumes: Divider 15 gives a 16-cycle flash tick
// Notes:   Busy length is judged to one tick either way since launch is not tick aligned
`timescale 1ns/1ns
module tb_flash_command_sequencer;
  localparam int          tk  = 16;
  localparam logic [31:0] arr = 32'h1 << flash_seq_pkg::array_sel_bit;
  localparam logic [31:0] st_a = 32'(flash_seq_pkg::status_off);
  localparam logic [31:0] cm_a = 32'(flash_seq_pkg::command_off);
  localparam logic [31:0] dv_a = 32'(flash_seq_pkg::clock_divider_off);
  logic        mclk_i = 1'b0, resetn_i = 1'b0, stop_mode_i = 1'b0, clk_en = 1'b1;
  logic        hsel, hwrite, hready, hresp, busy, hv;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          bad_count = 0, compares = 0;
  always #20 mclk_i = ~mclk_i;
  flash_bus_master u_bus (.mclk_i(mclk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr),
    .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));
  flash_command_sequencer u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .clk_en_i(clk_en), .stop_mode_i(stop_mode_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .flash_busy_o(busy),
    .high_voltage_o(hv));
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_bus.xfer(1'b1, a, d, x);
  endtask
  task rd(input logic [31:0] a, output logic [31:0] d);
    u_bus.xfer(1'b0, a, 32'h0, d);
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Full sequence, then busy length in ticks (0 means refused) and masked status
  task automatic run(input logic [7:0] c, input logic [15:0] a, input int n, input logic [31:0] m, input logic [31:0] e);
    int k;
    logic [31:0] s;
    wr(arr | a, {24'h0, a[7:0] ^ 8'h5a});
    wr(cm_a, {24'h0, c});
    wr(st_a, 32'h80);
    k = 0;
    while (busy !== 1'b1 && k < 40) begin
      @(negedge mclk_i);
      k++;
    end
    k = 0;
    while (busy === 1'b1 && k < 70000) begin
      @(negedge mclk_i);
      k++;
    end
    compares++;
    if (k < (n == 0 ? 0 : (n - 1) * tk + 1) || k > (n + 1) * tk) begin
      bad_count++;
      $display("BAD busy_cycles exp %0d ticks got %0d cycles", n, k);
    end
    if (m != 0) begin
      rd(st_a, s);
      chk("status", e, s & m);
    end
  endtask
  task results;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge mclk_i);
    bad_count++;
    results;
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rd(st_a, v);
    chk("status_reset", 32'hc0, v & 32'hd4);
    run(flash_seq_pkg::cmd_byte_program, 16'h0010, 0, 32'h10, 32'h10);
    wr(dv_a, 32'h0f);
    rd(dv_a, v);
    chk("divider_blocked", 32'h0, v);
    wr(st_a, 32'h10);
    rd(st_a, v);
    chk("status_cleared", 32'hc0, v & 32'hd4);
    wr(dv_a, 32'h0f);
    wr(dv_a, 32'h01);
    rd(dv_a, v);
    chk("divider_once", 32'h8f, v);
    run(flash_seq_pkg::cmd_byte_program, 16'h0123, 9, 32'hd4, 32'hc0);
    rd(32'(flash_seq_pkg::operand_addr_off), v);
    chk("latched_addr", 32'h0123, v);
    rd(32'(flash_seq_pkg::operand_data_off), v);
    chk("latched_data", 32'h79, v);
    run(flash_seq_pkg::cmd_blank_check, 16'h0200, 1, 32'hd4, 32'hc4);
    // The first two bursts skip the status read so the next one queues before the pump drops
    run(flash_seq_pkg::cmd_burst_program, 16'h0040, 9, 32'h0, 32'h0);
    run(flash_seq_pkg::cmd_burst_program, 16'h0041, 4, 32'h0, 32'h0);
    run(flash_seq_pkg::cmd_burst_program, 16'h0080, 9, 32'hd4, 32'hc0);
    wr(arr | 32'h10, 32'h1);
    wr(st_a, 32'h0);
    rd(st_a, v);
    chk("abort_err", 32'h10, v & 32'h10);
    run(flash_seq_pkg::cmd_byte_program, 16'h0011, 0, 32'h10, 32'h10);
    wr(st_a, 32'h10);
    wr(arr, 32'h0);
    wr(cm_a, 32'h33);
    rd(st_a, v);
    chk("bad_code_err", 32'h10, v & 32'h10);
    wr(st_a, 32'h10);
    run(flash_seq_pkg::cmd_page_erase, 16'h05ff, 4000, 32'hd4, 32'hc0);
    wr(arr | 32'h0600, 32'h0);
    wr(cm_a, {24'h0, flash_seq_pkg::cmd_mass_erase});
    wr(st_a, 32'h80);
    repeat (100) @(posedge mclk_i);
    wr(arr | 32'h0601, 32'h0);
    rd(st_a, v);
    chk("busy_write_err", 32'h10, v & 32'h10);
    wr(st_a, 32'h10);
    stop_mode_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("stop_busy", 32'h0, {31'h0, busy});
    @(posedge mclk_i);
    stop_mode_i <= 1'b0;
    rd(st_a, v);
    chk("stop_err", 32'h10, v & 32'h10);
    // A clear written while the clock enable is low must not land
    clk_en <= 1'b0;
    wr(st_a, 32'h10);
    clk_en <= 1'b1;
    rd(st_a, v);
    chk("frozen_clear", 32'h10, v & 32'h10);
    rd(32'h20, v);
    chk("unmapped", 32'h0, v);
    repeat (600) @(negedge mclk_i);
    results;
  end
endmodule // tb_flash_command_sequencer
